// >>> rtl/mrid_pkg.sv
// Package with constants and types of the instruction decoder.
package mrid_pkg;
   // ------------------------------------------------------------
   // File register map
   // ------------------------------------------------------------
   localparam logic [6:0] MRID_ADR_TIMER = 7'h01;
   localparam logic [6:0] MRID_ADR_STATUS = 7'h03;
   localparam logic [6:0] MRID_ADR_GPIO = 7'h05;
   localparam logic [6:0] MRID_ADR_PCHI = 7'h0a;
   localparam logic [6:0] MRID_ADR_IRQCTL = 7'h0b;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int MRID_BIT_C = 0;
   localparam int MRID_BIT_DC = 1;
   localparam int MRID_BIT_Z = 2;
   localparam int MRID_BIT_PD = 3;
   localparam int MRID_BIT_TO = 4;
   localparam int MRID_BIT_GIE = 7;
   localparam int MRID_CTRL_RUN = 0;
   localparam int MRID_CTRL_PSA = 1;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] MRID_STATUS_RST = 8'h18;
   localparam logic [1:0] MRID_CTRL_RST = 2'h0;
   localparam logic [12:0] MRID_PC_RST = 13'h0000;
   // ------------------------------------------------------------
   // Fixed instruction words
   // ------------------------------------------------------------
   localparam logic [13:0] MRID_OP_RETURN = 14'h0008;
   localparam logic [13:0] MRID_OP_RETIRQ = 14'h0009;
   localparam logic [13:0] MRID_OP_SLEEP = 14'h0063;
   localparam logic [13:0] MRID_OP_WDCLR = 14'h0064;
   // ------------------------------------------------------------
   // Wishbone register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] MRID_WB_CTRL = 8'h00;
   localparam logic [7:0] MRID_WB_WREG = 8'h04;
   localparam logic [7:0] MRID_WB_CORE = 8'h08;
   localparam logic [7:0] MRID_WB_WDOG = 8'h0c;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int MRID_CLK_PER_ICYCLE = 4;
   typedef enum logic [1:0] {MRID_Q1, MRID_Q2, MRID_Q3, MRID_Q4} mrid_phase_t;
endpackage : mrid_pkg

// >>> rtl/mrid_core.sv
// Instruction decoder and executor for the 14-bit mid-range instruction set.
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module mrid_core #(
   parameter int STACK_DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [13:0] instr_i,
   input wire logic [7:0] gpio_pins_i,
   input wire logic wake_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [12:0] pc_o,
   output logic [7:0] gpio_o,
   output logic gpio_read_o,
   output logic presc_clr_o,
   output logic sleeping_o
);
   localparam int SPW = $clog2(STACK_DEPTH);

   typedef struct packed {
      mrid_pkg::mrid_phase_t phase;
      logic [127:0][7:0] fr;
      logic [7:0] w;
      logic [12:0] pc;
      logic [STACK_DEPTH-1:0][12:0] stk;
      logic [SPW-1:0] sp;
      logic nop_next;
      logic hold_pc;
      logic sleeping;
      logic [7:0] wdt;
      logic [7:0] wdt_pre;
      logic [1:0] ctrl;
      logic ack;
      logic [31:0] rdat;
      logic gpio_rd;
      logic presc_clr;
   } mrid_state_t;

   mrid_state_t s_q;
   mrid_state_t s_d;

   logic [6:0] fadr;
   logic [7:0] fval;
   logic [7:0] res;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] st;
   logic wr_w;
   logic wr_f;
   logic skip;
   logic jump;
   logic file_op;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.ack = 1'b0;
      s_d.gpio_rd = 1'b0;
      s_d.presc_clr = 1'b0;
      fadr = instr_i[6:0];
      // Pin levels feed every read of the port register.
      fval = (fadr == mrid_pkg::MRID_ADR_GPIO) ? gpio_pins_i : s_q.fr[fadr];
      res = 8'h00;
      sum9 = 9'h000;
      sum5 = 5'h00;
      st = s_q.fr[mrid_pkg::MRID_ADR_STATUS];
      wr_w = 1'b0;
      wr_f = 1'b0;
      skip = 1'b0;
      jump = 1'b0;
      file_op = 1'b0;

      // ------------------------------------------------------------
      // Register bus
      // ------------------------------------------------------------
      if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
         s_d.ack = 1'b1;
         if (wb_we_i && wb_sel_i[0] && wb_adr_i == mrid_pkg::MRID_WB_CTRL) begin
            s_d.ctrl = wb_dat_i[1:0];
         end
         case (wb_adr_i)
            mrid_pkg::MRID_WB_CTRL: s_d.rdat = {30'h0, s_q.ctrl};
            mrid_pkg::MRID_WB_WREG: s_d.rdat = {24'h0, s_q.w};
            mrid_pkg::MRID_WB_CORE: s_d.rdat = {2'h0, s_q.sleeping, s_q.pc, 8'h0, st};
            mrid_pkg::MRID_WB_WDOG: s_d.rdat = {16'h0, s_q.wdt_pre, s_q.wdt};
            default: s_d.rdat = 32'h0;
         endcase
      end

      // ------------------------------------------------------------
      // Instruction execution
      // ------------------------------------------------------------
      if (s_q.ctrl[mrid_pkg::MRID_CTRL_RUN]) begin
         if (s_q.sleeping) begin
            if (wake_i) begin
               s_d.sleeping = 1'b0;
               s_d.wdt = 8'h00;
               s_d.wdt_pre = 8'h00;
            end
         end else begin
            case (s_q.phase)
               mrid_pkg::MRID_Q1: s_d.phase = mrid_pkg::MRID_Q2;
               mrid_pkg::MRID_Q2: s_d.phase = mrid_pkg::MRID_Q3;
               mrid_pkg::MRID_Q3: s_d.phase = mrid_pkg::MRID_Q4;
               default: s_d.phase = mrid_pkg::MRID_Q1;
            endcase
         end
         if (!s_q.sleeping && s_q.phase == mrid_pkg::MRID_Q4) begin
            s_d.wdt_pre = s_q.wdt_pre + 8'h01;
            if (s_q.wdt_pre == 8'hff) begin
               s_d.wdt = s_q.wdt + 8'h01;
            end
            // A taken jump already holds its target, so only a skip steps past the dropped word.
            s_d.pc = s_q.hold_pc ? s_q.pc : s_q.pc + 13'h0001;
            s_d.nop_next = 1'b0;
            s_d.hold_pc = 1'b0;
            if (!s_q.nop_next) begin
               case (instr_i[13:12])
                  2'b00: begin
                     // Clearing the working register names no file, so it reads none.
                     file_op = (instr_i[11:8] != 4'h0 && instr_i[11:8] != 4'h1) || instr_i[7];
                     case (instr_i[11:8])
                        4'h0: begin
                           if (instr_i[7]) begin
                              res = s_q.w;
                              wr_f = 1'b1;
                           end else if (instr_i == mrid_pkg::MRID_OP_RETURN) begin
                              jump = 1'b1;
                           end else if (instr_i == mrid_pkg::MRID_OP_RETIRQ) begin
                              jump = 1'b1;
                              s_d.fr[mrid_pkg::MRID_ADR_IRQCTL][mrid_pkg::MRID_BIT_GIE] =
                                 1'b1;
                           end else if (instr_i == mrid_pkg::MRID_OP_SLEEP) begin
                              s_d.wdt = 8'h00;
                              s_d.wdt_pre = 8'h00;
                              st[mrid_pkg::MRID_BIT_TO] = 1'b1;
                              st[mrid_pkg::MRID_BIT_PD] = 1'b0;
                              s_d.sleeping = 1'b1;
                           end else if (instr_i == mrid_pkg::MRID_OP_WDCLR) begin
                              s_d.wdt = 8'h00;
                              s_d.wdt_pre = 8'h00;
                              st[mrid_pkg::MRID_BIT_TO] = 1'b1;
                              st[mrid_pkg::MRID_BIT_PD] = 1'b1;
                           end
                        end
                        4'h1: begin
                           res = 8'h00;
                           wr_f = instr_i[7];
                           wr_w = !instr_i[7];
                           st[mrid_pkg::MRID_BIT_Z] = 1'b1;
                        end
                        4'h2, 4'h7: begin
                           if (instr_i[11:8] == 4'h7) begin
                              sum9 = {1'b0, fval} + {1'b0, s_q.w};
                              sum5 = {1'b0, fval[3:0]} + {1'b0, s_q.w[3:0]};
                           end else begin
                              sum9 = {1'b0, fval} + {1'b0, ~s_q.w} + 9'h001;
                              sum5 = {1'b0, fval[3:0]} + {1'b0, ~s_q.w[3:0]} + 5'h01;
                           end
                           res = sum9[7:0];
                           st[mrid_pkg::MRID_BIT_C] = sum9[8];
                           st[mrid_pkg::MRID_BIT_DC] = sum5[4];
                           st[mrid_pkg::MRID_BIT_Z] = (sum9[7:0] == 8'h00);
                        end
                        4'h3, 4'h9, 4'ha, 4'h8: begin
                           case (instr_i[11:8])
                              4'h3: res = fval - 8'h01;
                              4'h9: res = ~fval;
                              4'ha: res = fval + 8'h01;
                              default: res = fval;
                           endcase
                           st[mrid_pkg::MRID_BIT_Z] = (res == 8'h00);
                        end
                        4'h4, 4'h5, 4'h6: begin
                           case (instr_i[11:8])
                              4'h4: res = s_q.w | fval;
                              4'h5: res = s_q.w & fval;
                              default: res = s_q.w ^ fval;
                           endcase
                           st[mrid_pkg::MRID_BIT_Z] = (res == 8'h00);
                        end
                        4'hb, 4'hf: begin
                           res = (instr_i[11:8] == 4'hb) ? fval - 8'h01 : fval + 8'h01;
                           skip = (res == 8'h00);
                        end
                        4'hc: begin
                           res = {st[mrid_pkg::MRID_BIT_C], fval[7:1]};
                           st[mrid_pkg::MRID_BIT_C] = fval[0];
                        end
                        4'hd: begin
                           res = {fval[6:0], st[mrid_pkg::MRID_BIT_C]};
                           st[mrid_pkg::MRID_BIT_C] = fval[7];
                        end
                        default: res = {fval[3:0], fval[7:4]};
                     endcase
                     if (instr_i[11:8] > 4'h1) begin
                        wr_f = instr_i[7];
                        wr_w = !instr_i[7];
                     end
                  end
                  2'b01: begin
                     file_op = 1'b1;
                     res = fval;
                     case (instr_i[11:10])
                        2'b00: begin
                           res[instr_i[9:7]] = 1'b0;
                           wr_f = 1'b1;
                        end
                        2'b01: begin
                           res[instr_i[9:7]] = 1'b1;
                           wr_f = 1'b1;
                        end
                        2'b10: skip = !fval[instr_i[9:7]];
                        default: skip = fval[instr_i[9:7]];
                     endcase
                  end
                  2'b10: begin
                     jump = 1'b1;
                     s_d.pc = {s_q.fr[mrid_pkg::MRID_ADR_PCHI][4:3], instr_i[10:0]};
                     if (!instr_i[11]) begin
                        s_d.stk[s_q.sp] = s_q.pc + 13'h0001;
                        s_d.sp = s_q.sp + 1'b1;
                     end
                  end
                  default: begin
                     wr_w = 1'b1;
                     casez (instr_i[11:8])
                        4'b00??: res = instr_i[7:0];
                        4'b01??: begin
                           res = instr_i[7:0];
                           jump = 1'b1;
                        end
                        4'b1000: begin
                           res = s_q.w | instr_i[7:0];
                           st[mrid_pkg::MRID_BIT_Z] = (res == 8'h00);
                        end
                        4'b1001: begin
                           res = s_q.w & instr_i[7:0];
                           st[mrid_pkg::MRID_BIT_Z] = (res == 8'h00);
                        end
                        4'b1010: begin
                           res = s_q.w ^ instr_i[7:0];
                           st[mrid_pkg::MRID_BIT_Z] = (res == 8'h00);
                        end
                        4'b11??: begin
                           if (instr_i[9]) begin
                              sum9 = {1'b0, instr_i[7:0]} + {1'b0, s_q.w};
                              sum5 = {1'b0, instr_i[3:0]} + {1'b0, s_q.w[3:0]};
                           end else begin
                              sum9 = {1'b0, instr_i[7:0]} + {1'b0, ~s_q.w} + 9'h001;
                              sum5 = {1'b0, instr_i[3:0]} + {1'b0, ~s_q.w[3:0]} + 5'h01;
                           end
                           res = sum9[7:0];
                           st[mrid_pkg::MRID_BIT_C] = sum9[8];
                           st[mrid_pkg::MRID_BIT_DC] = sum5[4];
                           st[mrid_pkg::MRID_BIT_Z] = (sum9[7:0] == 8'h00);
                        end
                        default: wr_w = 1'b0;
                     endcase
                  end
               endcase
               // Returns pop the stack into the program counter.
               if (jump && instr_i[13:12] != 2'b10) begin
                  s_d.sp = s_q.sp - 1'b1;
                  s_d.pc = s_q.stk[s_q.sp - 1'b1];
               end
               if (file_op && fadr == mrid_pkg::MRID_ADR_GPIO) begin
                  s_d.gpio_rd = 1'b1;
               end
               if (wr_w) begin
                  s_d.w = res;
               end
               if (wr_f) begin
                  s_d.fr[fadr] = res;
                  if (fadr == mrid_pkg::MRID_ADR_TIMER) begin
                     s_d.presc_clr = s_q.ctrl[mrid_pkg::MRID_CTRL_PSA];
                  end
               end
               if (!(wr_f && fadr == mrid_pkg::MRID_ADR_STATUS)) begin
                  s_d.fr[mrid_pkg::MRID_ADR_STATUS] = st;
               end
               s_d.nop_next = skip || jump;
               s_d.hold_pc = jump;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.phase <= mrid_pkg::MRID_Q1;
         s_q.pc <= mrid_pkg::MRID_PC_RST;
         s_q.ctrl <= mrid_pkg::MRID_CTRL_RST;
         s_q.fr[mrid_pkg::MRID_ADR_STATUS] <= mrid_pkg::MRID_STATUS_RST;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o = s_q.rdat;
   assign wb_ack_o = s_q.ack;
   assign pc_o = s_q.pc;
   assign gpio_o = s_q.fr[mrid_pkg::MRID_ADR_GPIO];
   assign gpio_read_o = s_q.gpio_rd;
   assign presc_clr_o = s_q.presc_clr;
   assign sleeping_o = s_q.sleeping;
endmodule : mrid_core

// >>> bench/mrid_core_assertions.sv
// Checker with concurrent assertions on the ports of the instruction decoder core.
`timescale 1ns/1ps
module mrid_core_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [13:0] instr_i,
   input wire logic wake_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [12:0] pc_o,
   input wire logic [7:0] gpio_o,
   input wire logic gpio_read_o,
   input wire logic presc_clr_o,
   input wire logic sleeping_o
);
   // ------------------------------------------------------------
   // Helper logic
   // ------------------------------------------------------------
   // Keeps the word that was present at the last enabled edge.
   logic [13:0] instr_q;
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         instr_q <= instr_i;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("bus acknowledge held too long");
   ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("bus acknowledge missing");
   unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && ce_i
      && wb_adr_i == 8'h10 |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   pc_spacing_a: assert property ($changed(pc_o) |=> $stable(pc_o) [*3])
      else $error("program counter changed too soon");
   port_read_a: assert property (gpio_read_o |-> instr_q[6:0] == 7'h05)
      else $error("port read pulse without port address");
   presc_clear_a: assert property (presc_clr_o |-> instr_q[6:0] == 7'h01)
      else $error("prescaler clear without timer address");
   sleep_entry_a: assert property ($rose(sleeping_o) |-> instr_q == 14'h0063)
      else $error("standby entered without standby word");
   sleep_hold_a: assert property (sleeping_o && !wake_i && ce_i |=> sleeping_o)
      else $error("standby left without wake");
   wake_exit_a: assert property (sleeping_o && wake_i && ce_i |-> ##[1:8] !sleeping_o)
      else $error("standby not left after wake");
   ce_freeze_a: assert property (!ce_i |=> $stable(pc_o) && $stable(gpio_o) && $stable(sleeping_o))
      else $error("state moved while clock enable low");
endmodule : mrid_core_chk

bind mrid_core mrid_core_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .instr_i(instr_i), .wake_i(wake_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pc_o(pc_o), .gpio_o(gpio_o), .gpio_read_o(gpio_read_o), .presc_clr_o(presc_clr_o),
   .sleeping_o(sleeping_o));

// >>> bench/mrid_pmem.sv
// Program memory model that hands instruction words to the core.
`timescale 1ns/1ps
module mrid_pmem (
   input wire logic clk_i,
   input wire logic [12:0] pc_i,
   input wire logic we_i,
   input wire logic [3:0] wadr_i,
   input wire logic [13:0] wdat_i,
   output logic [13:0] instr_o
);
   logic [13:0] mem_q [16];
   // Answers one clock after the address, well inside the four clocks allowed.
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[wadr_i] <= wdat_i;
      end
      instr_o <= (pc_i < 13'h0010) ? mem_q[pc_i[3:0]] : 14'h0000;
   end
endmodule : mrid_pmem

// >>> bench/mrid_core_tb.sv
// Self-checking testbench for the instruction decoder core.
`timescale 1ns/1ps
module mrid_core_tb;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wake = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic pw = 1'b0, ack, grd, pcl, slp;
   logic [7:0] adr = 8'h00, pins = 8'ha5, gpo;
   logic [3:0] sel = 4'hf, pa = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, r;
   logic [13:0] pd = 14'h0000, instr;
   logic [12:0] pc;
   int mismatches = 0, n_tests = 0, n_pcl = 0, n_grd = 0, k = 0;

   mrid_core DUT (.clk_i(clk), .rst_i(rst), .ce_i(ce), .instr_i(instr), .gpio_pins_i(pins),
      .wake_i(wake), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pc_o(pc),
      .gpio_o(gpo), .gpio_read_o(grd), .presc_clr_o(pcl), .sleeping_o(slp));
   mrid_pmem u_pmem (.clk_i(clk), .pc_i(pc), .we_i(pw), .wadr_i(pa), .wdat_i(pd),
      .instr_o(instr));

   initial forever #20 clk = ~clk;
   always @(posedge clk) if (pcl === 1'b1 && ce === 1'b1) n_pcl <= n_pcl + 1;
   always @(posedge clk) if (grd === 1'b1 && ce === 1'b1) n_grd <= n_grd + 1;
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t ns: %s", $time, m);
      end
   endtask : chk
   // Loads eight words plus a jump-to-self at 8, then starts the core with a stall.
   task go(input logic [127:0] p, input logic [31:0] ctl);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         pa <= i[3:0];
         pd <= (i < 8) ? p[16*i +: 14] : ((i == 8) ? 14'h2808 : 14'h0000);
         pw <= 1'b1;
         @(posedge clk);
      end
      pw <= 1'b0;
      wb(1'b1, mrid_pkg::MRID_WB_CTRL, ctl);
      repeat (5) @(posedge clk);
      ce <= 1'b0;
      repeat (9) @(posedge clk);
      ce <= 1'b1;
   endtask : go
   task fin(input logic [7:0] ew, input logic [4:0] es, input string nm);
      while (pc !== 13'h0008) @(posedge clk);
      repeat (8) @(posedge clk);
      wb(1'b0, mrid_pkg::MRID_WB_WREG, 32'h0);
      chk(r, {24'h0, ew}, {nm, " working register"});
      wb(1'b0, mrid_pkg::MRID_WB_CORE, 32'h0);
      chk({27'h0, r[4:0]}, {27'h0, es}, {nm, " status"});
      $display("test %s done", nm);
   endtask : fin
   task t(input logic [127:0] p, input logic [7:0] ew, input logic [4:0] es, input string nm);
      go(p, 32'h1);
      fin(ew, es, nm);
   endtask : t
   task final_report;
      $display("checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, mrid_pkg::MRID_WB_CORE, 32'h0);
      chk(r & 32'h3fff_00ff, 32'h0000_0018, "core after reset");
      wb(1'b0, 8'h10, 32'h0);
      chk(r, 32'h0, "unmapped read");
      wb(1'b1, mrid_pkg::MRID_WB_CTRL, 32'h2);
      wb(1'b0, mrid_pkg::MRID_WB_CTRL, 32'h0);
      chk(r, 32'h2, "control readback");
      $display("test registers done");
      t(128'h0720_3001_00a0_300f, 8'h10, 5'h1a, "addf");
      t(128'h3e01_30ff, 8'h00, 5'h1f, "addl");
      t(128'h0220_3005_00a0_3003, 8'hfe, 5'h18, "subf");
      t(128'h3c05_3002, 8'h03, 5'h1b, "subl");
      t(128'h0820_06a0_300a_00a0_300c, 8'h06, 5'h18, "xorf");
      t(128'h0520_04a0_303c_00a0_30f0, 8'h3c, 5'h18, "andor");
      t(128'h390f_30f0, 8'h00, 5'h1c, "andl");
      t(128'h3805_3050, 8'h55, 5'h18, "orl");
      t(128'h0d20_00a0_3081, 8'h02, 5'h19, "rotl");
      t(128'h0c20_00a0_3001, 8'h00, 5'h19, "rotr");
      t(128'h3077_0b20_3033_00a0_3001, 8'h00, 5'h18, "decskip");
      t(128'h3e01_0f20_00a0_30fe, 8'h00, 5'h1f, "incskip");
      t(128'h3099_1da0_15a0_01a0_3011, 8'h11, 5'h1c, "bits1");
      t(128'h3e01_18a0_3022_1820_1020_00a0_30ff, 8'h00, 5'h1f, "bits2");
      t(128'h345a_0000_0000_0000_0000_2808_2006, 8'h5a, 5'h18, "call");
      t(128'h0008_304b_0000_0000_0000_0000_2808_2006, 8'h4b, 5'h18, "ret");
      t(128'h0009_0000_0000_2808_3980_080b_2006, 8'h80, 5'h18, "retirq");
      t(128'h3e01_0060_3355, 8'h56, 5'h18, "dontcare");
      t(128'h0e20_00a0_3012, 8'h21, 5'h18, "swap");
      t(128'h097f_00ff_30ff, 8'h00, 5'h1c, "comtop");
      k = n_grd;
      t(128'h0805_0085_305a, 8'ha5, 5'h18, "pins");
      chk({24'h0, gpo}, 32'h5a, "port latch");
      chk(n_grd - k, 32'h2, "port read pulses");
      for (int c = 1; c < 4; c += 2) begin
         k = n_pcl;
         go(128'h0081_3007, c);
         fin(8'h07, 5'h18, "timer");
         chk(n_pcl - k, c / 2, "prescaler clear count");
      end
      go(128'h303c_0064_0063, 32'h1);
      while (slp !== 1'b1) @(posedge clk);
      wb(1'b0, mrid_pkg::MRID_WB_CORE, 32'h0);
      chk({29'h0, r[29], r[4:3]}, 32'h6, "standby state");
      wb(1'b0, mrid_pkg::MRID_WB_WDOG, 32'h0);
      chk(r, 32'h0, "watchdog in standby");
      wake <= 1'b1;
      while (slp !== 1'b0) @(posedge clk);
      wake <= 1'b0;
      fin(8'h3c, 5'h18, "wake");
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      final_report();
   end
endmodule : mrid_core_tb
